//--- rtl/docs_pkg.sv
// Constants for the dual oscillator clock switch: register map,
// field positions, the fixed timer select reset value and divider figures.
// Assumes a 32-bit classic Wishbone bus with word-aligned registers.
package docs_pkg;

   // ***************************************************************
   // Register indices (byte address is four times the index)
   // ***************************************************************
   localparam logic [7:0] IDX_SOURCE_SELECTION = 8'h85;
   localparam logic [7:0] IDX_OSC_CONTROL = 8'h86;
   localparam logic [7:0] IDX_SWITCH_STATUS = 8'h87;
   localparam logic [7:0] IDX_CLOCK_CONTROL_ZERO = 8'h8F;
   localparam int ADR_W = 10;
   localparam int ADR_LSB = 2;

   // ***************************************************************
   // Field positions
   // ***************************************************************
   localparam int SOURCE_SELECT_BIT = 0;
   localparam int PRIMARY_EN_BIT = 0;
   localparam int SECONDARY_EN_BIT = 1;
   localparam int TIMER_SEL_BIT = 2;
   localparam int HALVER_BYPASS_BIT = 0;
   localparam int STAT_ACTIVE_BIT = 0;
   localparam int STAT_BUSY_BIT = 1;

   // ***************************************************************
   // Source codes and reset values
   // ***************************************************************
   localparam logic SRC_SECONDARY = 1'b0;
   localparam logic SRC_PRIMARY = 1'b1;
   localparam logic TIMER_FROM_PIN = 1'b0;
   localparam logic RST_TIMER_SEL = 1'b0;

   // ***************************************************************
   // Divider figures
   // ***************************************************************
   localparam int SUB_CLOCK_DIV = 128;
   localparam int SUB_DIV_W = $clog2(SUB_CLOCK_DIV);
   localparam int SWITCH_OSC_PERIODS = 2;

   // Handover sequencer states
   typedef enum logic [1:0] {
      DOCS_STEADY,
      DOCS_DROP_OLD,
      DOCS_TAKE_NEW
   } docs_sw_state_t;

endpackage : docs_pkg

//--- rtl/docs_clock_switch.sv
// Dual oscillator clock switch with Wishbone register access.
// Assumes both oscillator waveforms arrive already sampled to clk_i,
// which must run well above either oscillator.
//
// How it works
// [R01] Exactly one oscillator drives system clock; here none does while both gates are shut, after reset and mid-handover
// [R02] Select bit 0 secondary, 1 primary
// [R03] Changeover within two periods of each oscillator
// [R04] Secondary enable stays set while selected
// [R05] Primary enable stays set while selected
// [R06] Refuse selecting a disabled oscillator
// [R07] No settling check before switching
// [R08] Software enables, waits, switches, then disables
// [R09] Secondary also passes halver and prescaler; here it passes the halver only, there is no prescaler
// [R10] Idle keeps oscillators running, selection frozen
// [R11] Interrupt idle exit keeps control bits
// [R12] Reset reloads bits from oscillator fuse
// [R13] Power-down stops oscillators, freezes selection
// [R14] Enable bits power oscillators up or down
// [R15] Disabled secondary frees crystal pins
// [R16] Timer input: pin or secondary divided 128
// [R17] Speed bit: halve or pass through
// [R18] Speed bit resets to inverted fuse
// [R19] Oscillator fuse sets enables and select
// [R20] Glitch-free handover between oscillator gates
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module docs_clock_switch (
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [docs_pkg::ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Fuses and power modes
   input wire logic osc_select_fuse_i,
   input wire logic speed_fuse_i,
   input wire logic idle_i,
   input wire logic power_down_i,
   // Oscillators and pins
   input wire logic primary_oscillator_i,
   input wire logic secondary_oscillator_i,
   input wire logic timer_zero_ext_pin_i,
   output logic primary_osc_run_o,
   output logic secondary_osc_run_o,
   output logic crystal_pins_gpio_o,
   output logic timer_zero_count_o,
   output logic sys_clk_o,
   output logic active_source_o
);

   // ***************************************************************
   // Control bits
   // ***************************************************************
   logic source_select_bit;
   logic primary_osc_enable;
   logic secondary_osc_enable;
   logic sub_clock_timer_input_sel;
   logic clock_halver_bypass;

   // Bus decode
   logic bus_req;
   logic bus_wr;
   logic lane0;
   logic [7:0] reg_idx;
   logic frozen;

   // Handover state
   docs_pkg::docs_sw_state_t sw_state;
   logic gate_primary;
   logic gate_secondary;
   logic target_src;
   logic cur_src;
   logic muxed_clk;
   logic muxed_q;
   logic halved_clk;
   logic sec_q;
   logic [docs_pkg::SUB_DIV_W-1:0] sub_div;

   // Word index of a byte address
   function automatic logic [7:0] word_index(input logic [docs_pkg::ADR_W-1:0] adr);
      word_index = adr[docs_pkg::ADR_W-1:docs_pkg::ADR_LSB];
   endfunction : word_index

   // Level of the oscillator feeding a source code
   function automatic logic osc_level(input logic src, input logic pri, input logic sec);
      osc_level = (src == docs_pkg::SRC_PRIMARY) ? pri : sec;
   endfunction : osc_level

   // ***************************************************************
   // Wishbone slave
   // ***************************************************************
   // Request seen while ack is low; write lands on the ack edge
   assign bus_req = wb_cyc_i & wb_stb_i;
   assign bus_wr = bus_req & wb_we_i & wb_ack_o & lane0;
   assign lane0 = wb_sel_i[0];
   assign reg_idx = word_index(wb_adr_i);
   // Selection cannot move in idle or power-down
   assign frozen = idle_i | power_down_i; // R10 R13

   // Ack one cycle after the request, dropped the cycle after
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= bus_req & ~wb_ack_o;
      end
   end

   // Read data, zero for unmapped addresses
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (bus_req & ~wb_ack_o) begin
         wb_dat_o <= 32'h0000_0000;
         unique case (reg_idx)
            docs_pkg::IDX_SOURCE_SELECTION: begin
               wb_dat_o[docs_pkg::SOURCE_SELECT_BIT] <= source_select_bit;
            end
            docs_pkg::IDX_OSC_CONTROL: begin
               wb_dat_o[docs_pkg::PRIMARY_EN_BIT] <= primary_osc_enable;
               wb_dat_o[docs_pkg::SECONDARY_EN_BIT] <= secondary_osc_enable;
               wb_dat_o[docs_pkg::TIMER_SEL_BIT] <= sub_clock_timer_input_sel;
            end
            docs_pkg::IDX_SWITCH_STATUS: begin
               wb_dat_o[docs_pkg::STAT_ACTIVE_BIT] <= cur_src;
               wb_dat_o[docs_pkg::STAT_BUSY_BIT] <= (sw_state != docs_pkg::DOCS_STEADY);
            end
            docs_pkg::IDX_CLOCK_CONTROL_ZERO: begin
               wb_dat_o[docs_pkg::HALVER_BYPASS_BIT] <= clock_halver_bypass;
            end
            default: begin
               wb_dat_o <= 32'h0000_0000;
            end
         endcase
      end
   end

   // ***************************************************************
   // Source select bit
   // ***************************************************************
   // Fuse load at reset; guarded writes otherwise
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         source_select_bit <= osc_select_fuse_i; // R12 R19
      end else if (bus_wr && reg_idx == docs_pkg::IDX_SOURCE_SELECTION && !frozen) begin
         // No settling check is made here
         if (wb_dat_i[docs_pkg::SOURCE_SELECT_BIT] == docs_pkg::SRC_PRIMARY) begin
            if (primary_osc_enable) begin // R06 R07
               source_select_bit <= docs_pkg::SRC_PRIMARY; // R02
            end
         end else if (secondary_osc_enable) begin // R06
            source_select_bit <= docs_pkg::SRC_SECONDARY; // R02
         end
      end
   end

   // ***************************************************************
   // Oscillator control register
   // ***************************************************************
   // Enables refuse clearing of the selected source
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         primary_osc_enable <= osc_select_fuse_i; // R12 R19
         secondary_osc_enable <= ~osc_select_fuse_i; // R12 R19
         sub_clock_timer_input_sel <= docs_pkg::RST_TIMER_SEL;
      end else if (bus_wr && reg_idx == docs_pkg::IDX_OSC_CONTROL) begin // R11
         primary_osc_enable <= wb_dat_i[docs_pkg::PRIMARY_EN_BIT]
            | (source_select_bit == docs_pkg::SRC_PRIMARY); // R05
         secondary_osc_enable <= wb_dat_i[docs_pkg::SECONDARY_EN_BIT]
            | (source_select_bit == docs_pkg::SRC_SECONDARY); // R04
         sub_clock_timer_input_sel <= wb_dat_i[docs_pkg::TIMER_SEL_BIT];
      end
   end

   // Speed bit, reset to inverted fuse, always writable
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         clock_halver_bypass <= ~speed_fuse_i; // R18
      end else if (bus_wr && reg_idx == docs_pkg::IDX_CLOCK_CONTROL_ZERO) begin
         clock_halver_bypass <= wb_dat_i[docs_pkg::HALVER_BYPASS_BIT]; // R18
      end
   end

   // ***************************************************************
   // Oscillator power and pins
   // ***************************************************************
   // Enabled oscillators run, also in idle; all stop in power-down
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         primary_osc_run_o <= 1'b0;
         secondary_osc_run_o <= 1'b0;
         crystal_pins_gpio_o <= 1'b0;
      end else begin
         primary_osc_run_o <= primary_osc_enable & ~power_down_i; // R14 R10 R13
         secondary_osc_run_o <= secondary_osc_enable & ~power_down_i; // R14 R10 R13
         crystal_pins_gpio_o <= ~secondary_osc_enable; // R15
      end
   end

   // ***************************************************************
   // Glitch-free handover
   // ***************************************************************
   // Old gate closes while its clock is low, then new opens while low
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sw_state <= docs_pkg::DOCS_STEADY;
         gate_primary <= 1'b0;
         gate_secondary <= 1'b0;
         cur_src <= docs_pkg::SRC_SECONDARY;
         target_src <= docs_pkg::SRC_SECONDARY;
      end else begin
         unique case (sw_state)
            docs_pkg::DOCS_STEADY: begin
               if (!gate_primary && !gate_secondary) begin
                  // First start after reset: open selected gate
                  target_src <= source_select_bit;
                  sw_state <= docs_pkg::DOCS_TAKE_NEW;
               end else if (source_select_bit != cur_src) begin
                  target_src <= source_select_bit;
                  sw_state <= docs_pkg::DOCS_DROP_OLD; // R03
               end
            end
            docs_pkg::DOCS_DROP_OLD: begin
               if (!osc_level(cur_src, primary_oscillator_i, secondary_oscillator_i)) begin
                  gate_primary <= 1'b0; // R20
                  gate_secondary <= 1'b0; // R20
                  sw_state <= docs_pkg::DOCS_TAKE_NEW;
               end
            end
            docs_pkg::DOCS_TAKE_NEW: begin
               if (!osc_level(target_src, primary_oscillator_i, secondary_oscillator_i)) begin
                  gate_primary <= (target_src == docs_pkg::SRC_PRIMARY); // R01 R20
                  gate_secondary <= (target_src == docs_pkg::SRC_SECONDARY); // R01 R20
                  cur_src <= target_src;
                  sw_state <= docs_pkg::DOCS_STEADY; // R03
               end
            end
         endcase
      end
   end

   // One gated oscillator reaches the clock path
   assign muxed_clk = (gate_primary & primary_oscillator_i)
      | (gate_secondary & secondary_oscillator_i); // R01

   // ***************************************************************
   // Halver and system clock
   // ***************************************************************
   // Both sources share the halver path
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         muxed_q <= 1'b0;
         halved_clk <= 1'b0;
         sys_clk_o <= 1'b0;
         active_source_o <= 1'b0;
      end else begin
         muxed_q <= muxed_clk;
         if (muxed_clk && !muxed_q) begin
            halved_clk <= ~halved_clk; // R17 R09
         end
         sys_clk_o <= clock_halver_bypass ? muxed_clk : halved_clk; // R17 R09
         active_source_o <= cur_src;
      end
   end

   // ***************************************************************
   // Timer zero count input
   // ***************************************************************
   // Secondary oscillator divided by 128, or the external pin
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sec_q <= 1'b0;
         sub_div <= '0;
         timer_zero_count_o <= 1'b0;
      end else begin
         sec_q <= secondary_oscillator_i;
         if (secondary_oscillator_i && !sec_q) begin
            sub_div <= sub_div + 1'b1; // R16
         end
         timer_zero_count_o <= (sub_clock_timer_input_sel == docs_pkg::TIMER_FROM_PIN)
            ? timer_zero_ext_pin_i : sub_div[docs_pkg::SUB_DIV_W-1]; // R16
      end
   end

   // ***************************************************************
   // Checks
   // ***************************************************************
   // Never two gates at once
   property p_one_gate; // R01
      @(posedge clk_i) disable iff (rst_i) !(gate_primary && gate_secondary);
   endproperty
   a_one_gate: assert property (p_one_gate) else $error("both oscillator gates open"); // R01

   // Selected source always has its enable set
   property p_selected_enabled; // R04
      @(posedge clk_i) disable iff (rst_i)
         (source_select_bit ? primary_osc_enable : secondary_osc_enable);
   endproperty
   a_selected_enabled: assert property (p_selected_enabled) else $error("active source disabled"); // R04

   // Clearing primary while selected is refused
   property p_keep_primary; // R05
      @(posedge clk_i) disable iff (rst_i)
         (bus_wr && reg_idx == docs_pkg::IDX_OSC_CONTROL && source_select_bit
          && !wb_dat_i[docs_pkg::PRIMARY_EN_BIT]) |=> primary_osc_enable;
   endproperty
   a_keep_primary: assert property (p_keep_primary) else $error("primary cleared while active"); // R05

   // Select change only toward an enabled source
   property p_select_enabled; // R06
      @(posedge clk_i) disable iff (rst_i)
         $changed(source_select_bit) |->
            ($past(source_select_bit) ? $past(secondary_osc_enable) : $past(primary_osc_enable));
   endproperty
   a_select_enabled: assert property (p_select_enabled) else $error("switched to disabled source"); // R06

   // Selection frozen in idle or power-down
   property p_frozen; // R10
      @(posedge clk_i) disable iff (rst_i) $past(frozen) |-> $stable(source_select_bit);
   endproperty
   a_frozen: assert property (p_frozen) else $error("source changed while frozen"); // R10

   // Power-down stops oscillators next cycle
   property p_pd_stop; // R13
      @(posedge clk_i) disable iff (rst_i)
         power_down_i |=> !primary_osc_run_o && !secondary_osc_run_o;
   endproperty
   a_pd_stop: assert property (p_pd_stop) else $error("oscillator runs in power-down"); // R13

   // Pins freed exactly when secondary is off
   property p_pins; // R15
      @(posedge clk_i) disable iff (rst_i)
         !rst_i |=> crystal_pins_gpio_o == !$past(secondary_osc_enable);
   endproperty
   a_pins: assert property (p_pins) else $error("crystal pin release wrong"); // R15

   // Timer pin routed when selector is zero
   property p_timer_pin; // R16
      @(posedge clk_i) disable iff (rst_i)
         !sub_clock_timer_input_sel |=> timer_zero_count_o == $past(timer_zero_ext_pin_i);
   endproperty
   a_timer_pin: assert property (p_timer_pin) else $error("timer input not from pin"); // R16

   // Bypass passes the gated clock through
   property p_bypass; // R17
      @(posedge clk_i) disable iff (rst_i)
         clock_halver_bypass |=> sys_clk_o == $past(muxed_clk);
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypass clock mismatch"); // R17

   // Primary gate opens only while primary clock is low
   property p_glitch_free; // R20
      @(posedge clk_i) disable iff (rst_i)
         $rose(gate_primary) |-> !$past(primary_oscillator_i);
   endproperty
   a_glitch_free: assert property (p_glitch_free) else $error("primary gate opened high"); // R20

endmodule : docs_clock_switch

`default_nettype wire

//--- test/test_dual_oscillator_clock_switch.sv
// Self-checking bench for the dual oscillator clock switch.
// Assumes docs_pkg and docs_clock_switch are compiled before this file.
`timescale 1ns/1ps
`default_nettype none

module test_dual_oscillator_clock_switch;
   // ***************************************************************
   // Stimulus and design hookup
   // ***************************************************************
   localparam int PA = 8;
   localparam int PB = 12;
   localparam int LIMIT = 20000;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [docs_pkg::ADR_W-1:0] wb_adr_i = '0;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic osc_fuse = 1'b1;
   logic speed_fuse = 1'b0;
   logic idle_i = 1'b0;
   logic power_down_i = 1'b0;
   logic pin = 1'b0;
   logic [7:0] pa_cnt = 8'h00;
   logic [7:0] pb_cnt = 8'h00;
   logic osc_a;
   logic osc_b;
   logic prim_run, sec_run, gpio, tmr, sys_clk, active;
   logic [31:0] r;
   int n_fail = 0;
   int compares = 0;
   int cycles = 0;

   // Clock and the two oscillator waveforms
   always #2.5 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      pa_cnt <= (pa_cnt == PA - 1) ? 8'h00 : pa_cnt + 8'h01;
      pb_cnt <= (pb_cnt == PB - 1) ? 8'h00 : pb_cnt + 8'h01;
   end
   assign osc_a = (pa_cnt < PA / 2);
   assign osc_b = (pb_cnt < PB / 2);

   docs_clock_switch i_docs_clock_switch (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .osc_select_fuse_i(osc_fuse), .speed_fuse_i(speed_fuse), .idle_i(idle_i),
      .power_down_i(power_down_i), .primary_oscillator_i(osc_a),
      .secondary_oscillator_i(osc_b), .timer_zero_ext_pin_i(pin),
      .primary_osc_run_o(prim_run), .secondary_osc_run_o(sec_run),
      .crystal_pins_gpio_o(gpio), .timer_zero_count_o(tmr),
      .sys_clk_o(sys_clk), .active_source_o(active));

   // ***************************************************************
   // Bus tasks, comparisons and verdict
   // ***************************************************************
   task automatic close_out();
      $display("compares %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : close_out

   // Hang guard
   always @(posedge clk_i) begin
      cycles = cycles + 1;
      if (cycles == LIMIT) begin
         n_fail++;
         close_out();
      end
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // One classic Wishbone cycle, held until ack is sampled
   task automatic xfer(input logic we, input logic [7:0] idx, input logic [3:0] sel,
                       input logic [31:0] wd, output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= {idx, 2'b00};
      wb_sel_i <= sel;
      wb_dat_i <= wd;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      rd = wb_dat_o;
      if (n >= 50) chk("wb ack", 32'h1, 32'h0);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask : xfer

   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      logic [31:0] dummy;
      xfer(1'b1, idx, 4'h1, d, dummy);
   endtask : wr

   task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp, input string what);
      logic [31:0] got;
      xfer(1'b0, idx, 4'h1, 32'h0, got);
      chk(what, exp, got);
   endtask : rd_chk

   // Waits a bounded number of cycles for the active source flag
   task automatic wait_active(input logic exp, input int bound);
      int n;
      for (n = 0; n < bound && active !== exp; n++) @(posedge clk_i);
      chk("active source", {31'h0, exp}, {31'h0, active});
   endtask : wait_active

   // Cycles between two rising edges of sys clock or timer input
   task automatic period_chk(input logic use_tmr, input int exp, input string what);
      int n;
      int rises;
      int span;
      logic prev;
      logic cur;
      n = 0;
      rises = 0;
      span = 0;
      prev = 1'b1;
      while (rises < 2 && n < 4 * exp + 20) begin
         @(posedge clk_i);
         n++;
         cur = use_tmr ? tmr : sys_clk;
         if (rises == 1) span++;
         if (cur === 1'b1 && prev === 1'b0) rises++;
         prev = cur;
      end
      chk(what, exp, span);
   endtask : period_chk

   task automatic do_reset(input logic f, input logic x);
      @(posedge clk_i);
      rst_i <= 1'b1;
      osc_fuse <= f;
      speed_fuse <= x;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
   endtask : do_reset

   // ***************************************************************
   // Test sequence
   // ***************************************************************
   initial begin
      do_reset(1'b1, 1'b0);
      wait_active(1'b1, 20);
      rd_chk(8'h85, 32'h1, "select");
      rd_chk(8'h86, 32'h1, "control");
      rd_chk(8'h8F, 32'h1, "speed bit");
      rd_chk(8'h87, 32'h1, "status");
      wr(8'h90, 32'hFF);
      rd_chk(8'h90, 32'h0, "unmapped");
      chk("crystal pins free", 32'h1, {31'h0, gpio});
      chk("secondary run", 32'h0, {31'h0, sec_run});
      chk("primary run", 32'h1, {31'h0, prim_run});
      period_chk(1'b0, PA, "primary sys clock");
      $display("test defaults done");
      wr(8'h86, 32'h0);
      rd_chk(8'h86, 32'h1, "primary enable held");
      wr(8'h85, 32'h0);
      rd_chk(8'h85, 32'h1, "select to disabled");
      xfer(1'b1, 8'h86, 4'h0, 32'h3, r);
      rd_chk(8'h86, 32'h1, "lane masked write");
      wr(8'h87, 32'hFF);
      rd_chk(8'h87, 32'h1, "status read only");
      $display("test interlocks done");
      wr(8'h86, 32'h3);
      repeat (3) @(posedge clk_i);
      chk("crystal pins held", 32'h0, {31'h0, gpio});
      wr(8'h85, 32'h0);
      wait_active(1'b0, 2 * (PA + PB) + 4);
      rd_chk(8'h87, 32'h0, "status after switch");
      wr(8'h86, 32'h2);
      rd_chk(8'h86, 32'h2, "old enable cleared");
      wr(8'h86, 32'h0);
      rd_chk(8'h86, 32'h2, "secondary enable held");
      chk("primary stopped", 32'h0, {31'h0, prim_run});
      period_chk(1'b0, PB, "secondary sys clock");
      wr(8'h8F, 32'h0);
      rd_chk(8'h8F, 32'h0, "speed bit rewrite");
      period_chk(1'b0, 2 * PB, "halved secondary");
      $display("test switch done");
      pin <= 1'b1;
      repeat (3) @(posedge clk_i);
      chk("timer pin high", 32'h1, {31'h0, tmr});
      pin <= 1'b0;
      repeat (3) @(posedge clk_i);
      chk("timer pin low", 32'h0, {31'h0, tmr});
      wr(8'h86, 32'h6);
      period_chk(1'b1, 128 * PB, "sub clock timer");
      $display("test timer input done");
      wr(8'h86, 32'h3);
      idle_i <= 1'b1;
      wr(8'h85, 32'h1);
      rd_chk(8'h85, 32'h0, "select frozen in idle");
      chk("idle primary run", 32'h1, {31'h0, prim_run});
      chk("idle secondary run", 32'h1, {31'h0, sec_run});
      idle_i <= 1'b0;
      rd_chk(8'h85, 32'h0, "select after idle");
      rd_chk(8'h86, 32'h3, "control after idle");
      power_down_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      chk("pd primary run", 32'h0, {31'h0, prim_run});
      chk("pd secondary run", 32'h0, {31'h0, sec_run});
      wr(8'h85, 32'h1);
      rd_chk(8'h85, 32'h0, "select frozen in pd");
      power_down_i <= 1'b0;
      rd_chk(8'h86, 32'h3, "control after pd");
      wr(8'h85, 32'h1);
      wait_active(1'b1, 2 * (PA + PB) + 4);
      period_chk(1'b0, 2 * PA, "halved primary");
      $display("test power modes done");
      do_reset(1'b0, 1'b1);
      rd_chk(8'h85, 32'h0, "select fuse low");
      rd_chk(8'h86, 32'h2, "control fuse low");
      rd_chk(8'h8F, 32'h0, "speed fuse high");
      wait_active(1'b0, 20);
      period_chk(1'b0, 2 * PB, "fuse low sys clock");
      wr(8'h8F, 32'h1);
      rd_chk(8'h8F, 32'h1, "speed bit set");
      $display("test second reset done");
      close_out();
   end
endmodule : test_dual_oscillator_clock_switch

`default_nettype wire
